// [logic/pzt_pkg.sv]
// Constants and types for the zero, analogue window and preset block
package pzt_pkg;
  localparam int VW = 32;                                   // Value width
  localparam logic signed [31:0] ZERO_DEF  = 32'sh0000_0000; // Zero datum
  localparam logic signed [31:0] PRE1_DEF  = 32'sh0000_2710; // 10000
  localparam logic signed [31:0] PRE2_DEF  = 32'sh0000_1388; // 5000
  localparam logic signed [31:0] HYS_DEF   = 32'sh0000_0000; // Deadband
  localparam logic signed [31:0] AOFS_DEF  = 32'sh0000_0000; // 0,000
  localparam logic signed [31:0] AGAIN_DEF = 32'sh0000_03E8; // 10,00 x100
  localparam logic signed [31:0] WBEG_DEF  = 32'sh0000_0000; // Begin 0
  localparam logic signed [31:0] WEND_DEF  = 32'sh0001_86A0; // End 100000
  localparam logic signed [31:0] IPT_DEF   = 32'sh000F_423F; // 999999
  localparam logic signed [31:0] VAL_MIN   = -32'sh0003_0D3F; // -199999
  localparam logic signed [31:0] VAL_MAX   = 32'sh000F_423F;  // 999999
  localparam int NPTS = 16;                                 // Point pairs
  localparam int CLK_HZ     = 200_000_000;                  // Clock rate
  localparam int PULSE_MS   = 500;                          // Pulse length
  localparam int STATUS_MS  = 2000;                         // Status show
  localparam int PULSE_CYC  = CLK_HZ / 1000 * PULSE_MS;      // Cycles
  localparam int STATUS_CYC = CLK_HZ / 1000 * STATUS_MS;     // Cycles
  localparam logic [15:0] UNITY = 16'h03E8;                 // 1.000 x1000
  localparam logic [31:0] SCALE_K = 32'h0000_03E8;          // Factor scale
  localparam logic [31:0] SPAN_FS = 32'h0000_FFFF;          // DAC code span
  localparam logic signed [31:0] I4_BASE = 32'sh0000_0FA0;  // 4 mA floor, uA

  typedef enum logic [1:0] {                                // Zero source
    PZT_SRC_OFF  = 2'b00,
    PZT_SRC_KEY  = 2'b01,
    PZT_SRC_REM  = 2'b10,
    PZT_SRC_BOTH = 2'b11
  } pzt_src_t;

  typedef enum logic [1:0] {                                // Analogue mode
    PZT_AM_BIP10 = 2'b00,
    PZT_AM_UNI10 = 2'b01,
    PZT_AM_I4_20 = 2'b10,
    PZT_AM_I0_20 = 2'b11
  } pzt_amode_t;

  typedef enum logic [2:0] {                                // Output mode
    PZT_OM_GE_S  = 3'b000,
    PZT_OM_LE_S  = 3'b001,
    PZT_OM_GE_D  = 3'b010,
    PZT_OM_LE_D  = 3'b011,
    PZT_OM_TR_S  = 3'b100,
    PZT_OM_TR_D  = 3'b101
  } pzt_omode_t;

  typedef enum logic [1:0] {                                // Status codes
    PZT_ST_NONE = 2'b00,
    PZT_ST_BOTH = 2'b01,
    PZT_ST_ONE  = 2'b10,
    PZT_ST_TWO  = 2'b11
  } pzt_stat_t;
endpackage

// [logic/pzt_core.sv]
// Zero capture, display scaling, analogue window and two preset outputs
//
// Summary of operation
// - Zero command captures current position as datum
// - Source select: off, key, remote, both
// - Datum kept in retained register, nv port
// - Display zero when position equals datum
// - Direct write or reset, latest wins; reset wins in the same cycle
// - Additive offset shifts displayed zero
// - Sixteen point pairs, writable only if linearized
// - Four analogue modes, bipolar follows sign
// - Analogue offset sets zero-state level
// - Gain sets swing, doubled in 0-20 mA, x1.6 in 4-20 mA
// - Begin/end window mapped linearly to output
// - Window compares scaled display value
// - Static outputs on at threshold GE/LE
// - Dynamic mode gives one 500 ms pulse
// - Output two trailing: value >= pre1 - pre2
// - Presets default 10000 and 5000, signed
// - Per-output deadband, side follows GE/LE
// - Enter tap shows output state for 2 s
// - Display is scaled position plus offset
`timescale 1ns/1ps
`default_nettype none
module pzt_core #(
  parameter int PULSE_CYC  = pzt_pkg::PULSE_CYC,   // Pulse length cycles
  parameter int STATUS_CYC = pzt_pkg::STATUS_CYC   // Status show cycles
) (
  input  wire logic                sys_clk_i,      // System clock
  input  wire logic                rst_b_i,        // Sync reset, low
  input  wire logic                ce_i,           // Clock enable
  input  wire logic signed [31:0]  pos_i,          // Bit-blanked position
  input  wire logic                pos_vld_i,      // New position strobe
  input  wire logic signed [15:0]  mul_fac_i,      // Multiply x1000
  input  wire logic        [15:0]  div_fac_i,      // Divide x1000
  input  wire logic signed [31:0]  add_fac_i,      // Additive factor
  input  wire logic        [1:0]   zero_capture_source_i, // Source select
  input  wire logic                key_set_i,      // Front key pulse
  input  wire logic                remote_input_source_i, // Remote pin
  input  wire logic                zero_wr_i,      // Direct datum write
  input  wire logic signed [31:0]  zero_wdata_i,   // Datum write value
  input  wire logic signed [31:0]  zero_nv_i,      // Stored datum at boot
  output logic signed [31:0]       zero_position_value_o, // Datum
  output logic                     zero_nv_wr_o,   // Store datum pulse
  input  wire logic                lin_en_i,       // Linearization on
  input  wire logic                pt_wr_i,        // Point write
  input  wire logic        [3:0]   pt_idx_i,       // Point index
  input  wire logic                pt_sel_y_i,     // Write Y not X
  input  wire logic signed [31:0]  pt_wdata_i,     // Point value
  output logic signed [31:0]       pt_x_o,         // X at index
  output logic signed [31:0]       pt_y_o,         // Y at index
  output logic                     pt_wr_ok_o,     // Write accepted
  input  wire logic        [1:0]   amode_i,        // Analogue mode
  input  wire logic signed [31:0]  analog_zero_level_i, // Offset x1000
  input  wire logic        [31:0]  analog_swing_i, // Gain x100
  input  wire logic signed [31:0]  analog_window_begin_i, // Window begin
  input  wire logic signed [31:0]  analog_window_end_i,   // Window end
  output logic signed [31:0]       aout_o,         // Level, mV or uA
  output logic                     aout_neg_o,     // Bipolar sign
  input  wire logic        [2:0]   omode1_i,       // Output one mode
  input  wire logic        [2:0]   omode2_i,       // Output two mode
  input  wire logic signed [31:0]  pre1_i,         // Preselection one
  input  wire logic signed [31:0]  pre2_i,         // Preselection two
  input  wire logic signed [31:0]  output_one_deadband_i, // Hyst one
  input  wire logic signed [31:0]  output_two_deadband_i, // Hyst two
  output logic                     out1_o,         // Switching output 1
  output logic                     out2_o,         // Switching output 2
  input  wire logic                enter_tap_i,    // Enter key tap
  output logic                     stat_show_o,    // Status shown
  output logic             [1:0]   stat_code_o,    // Status code
  output logic signed [31:0]       disp_o          // Display value
);

  // Remote pin synchroniser
  logic rem_s1_q;                                   // First stage
  logic rem_s2_q;                                   // Second stage
  logic rem_s3_q;                                   // Edge history
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      rem_s1_q <= 1'b0;
      rem_s2_q <= 1'b0;
      rem_s3_q <= 1'b0;
    end else if (ce_i) begin
      rem_s1_q <= remote_input_source_i;
      rem_s2_q <= rem_s1_q;
      rem_s3_q <= rem_s2_q;
    end
  end
  logic rem_evt;                                    // Remote rising edge
  assign rem_evt = rem_s2_q & ~rem_s3_q;

  // Zero command qualification
  logic zero_cmd;                                   // Accepted command
  always_comb begin
    unique case (pzt_pkg::pzt_src_t'(zero_capture_source_i))
      pzt_pkg::PZT_SRC_OFF:  zero_cmd = 1'b0;
      pzt_pkg::PZT_SRC_KEY:  zero_cmd = key_set_i;
      pzt_pkg::PZT_SRC_REM:  zero_cmd = rem_evt;
      pzt_pkg::PZT_SRC_BOTH: zero_cmd = key_set_i | rem_evt;
    endcase
  end

  // Latest raw position
  logic signed [31:0] pos_q;                        // Held position
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) pos_q <= 32'sh0000_0000;
    else if (ce_i && pos_vld_i) pos_q <= pos_i;
  end

  // Datum register, reloaded from retained store after reset
  logic signed [31:0] zero_q;                       // Datum
  logic               boot_q;                       // Load pending
  logic               nvwr_q;                       // Store pulse
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      zero_q <= pzt_pkg::ZERO_DEF;
      boot_q <= 1'b1;
      nvwr_q <= 1'b0;
    end else if (ce_i) begin
      boot_q <= 1'b0;
      nvwr_q <= 1'b0;
      if (boot_q) begin
        zero_q <= zero_nv_i;
      end else if (zero_cmd) begin
        zero_q <= pos_q;
        nvwr_q <= 1'b1;
      end else if (zero_wr_i) begin
        zero_q <= zero_wdata_i;
        nvwr_q <= 1'b1;
      end
    end
  end
  assign zero_position_value_o = zero_q;
  assign zero_nv_wr_o          = nvwr_q;

  // Display: (pos - datum) * M / D + P, 64-bit signed
  logic signed [63:0] diff_w;                       // Referenced position
  logic signed [63:0] prod_w;                       // Scaled product
  logic signed [63:0] quot_w;                       // After divide
  logic signed [31:0] disp_q;                       // Display value
  always_comb begin
    diff_w = 64'(pos_q) - 64'(zero_q);
    prod_w = diff_w * 64'(mul_fac_i);
    quot_w = (div_fac_i == 16'h0000) ? prod_w
           : prod_w / $signed({48'h0000_0000_0000, div_fac_i});
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) disp_q <= 32'sh0000_0000;
    else if (ce_i) disp_q <= 32'(quot_w + 64'(add_fac_i));
  end
  assign disp_o = disp_q;

  // Interpolation point storage
  logic signed [31:0] px_q [pzt_pkg::NPTS];         // X values
  logic signed [31:0] py_q [pzt_pkg::NPTS];         // Y values
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < pzt_pkg::NPTS; i++) begin
        px_q[i] <= pzt_pkg::IPT_DEF;
        py_q[i] <= pzt_pkg::IPT_DEF;
      end
    end else if (ce_i && pt_wr_i && lin_en_i) begin
      if (pt_sel_y_i) py_q[pt_idx_i] <= pt_wdata_i;
      else            px_q[pt_idx_i] <= pt_wdata_i;
    end
  end
  assign pt_x_o     = lin_en_i ? px_q[pt_idx_i] : 32'sh0000_0000;
  assign pt_y_o     = lin_en_i ? py_q[pt_idx_i] : 32'sh0000_0000;
  assign pt_wr_ok_o = pt_wr_i & lin_en_i;

  // Analogue window mapping, result in mV or uA
  logic signed [63:0] span_w;                       // Window width
  logic signed [63:0] rel_w;                        // Clamped position
  logic signed [63:0] frac_w;                       // Level above floor
  logic signed [63:0] sw_w;                         // Swing mV or uA
  logic signed [63:0] lvl_w;                        // Output level
  logic signed [63:0] mag_w;                        // Bipolar magnitude
  // One divide over the whole swing, so no code-step rounding is lost
  always_comb begin
    span_w = 64'(analog_window_end_i) - 64'(analog_window_begin_i);
    rel_w  = 64'(disp_q) - 64'(analog_window_begin_i);
    mag_w  = (disp_q < 0) ? -64'(disp_q) : 64'(disp_q);
    if (amode_i == pzt_pkg::PZT_AM_BIP10)
      rel_w = mag_w - 64'(analog_window_begin_i);
    if (rel_w < 0) rel_w = 64'sd0;                  // Below window
    if (rel_w > span_w) rel_w = span_w;             // Above window
    sw_w = 64'(analog_swing_i) * 64'sd10;
    if (amode_i == pzt_pkg::PZT_AM_I4_20 ||
        amode_i == pzt_pkg::PZT_AM_I0_20)
      sw_w = sw_w * 64'sd2;
    if (amode_i == pzt_pkg::PZT_AM_I4_20)
      sw_w = sw_w - sw_w / 64'sd5;                  // Span above the floor
    if (span_w <= 0) frac_w = 64'sd0;               // Empty window
    else frac_w = rel_w * sw_w / span_w;
    lvl_w = frac_w + 64'(analog_zero_level_i);
    if (amode_i == pzt_pkg::PZT_AM_I4_20)
      lvl_w = lvl_w + 64'(pzt_pkg::I4_BASE);
  end
  logic signed [31:0] aout_q;                       // Level register
  logic               aneg_q;                       // Sign register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      aout_q <= 32'sh0000_0000;
      aneg_q <= 1'b0;
    end else if (ce_i) begin
      aout_q <= 32'(lvl_w);
      aneg_q <= (amode_i == pzt_pkg::PZT_AM_BIP10) && (disp_q < 0);
    end
  end
  assign aout_o     = aout_q;
  assign aout_neg_o = aneg_q;

  // Comparators with deadband
  logic signed [33:0] thr1, thr2;                   // Effective thresholds
  logic               le1, le2;                     // LE characteristic
  logic               dyn1, dyn2;                   // Pulsed mode
  logic               st1_q, st2_q;                 // Comparison states
  always_comb begin
    thr1 = 34'(pre1_i);
    le1  = (omode1_i == pzt_pkg::PZT_OM_LE_S) ||
           (omode1_i == pzt_pkg::PZT_OM_LE_D);
    dyn1 = (omode1_i == pzt_pkg::PZT_OM_GE_D) ||
           (omode1_i == pzt_pkg::PZT_OM_LE_D);
    thr2 = 34'(pre2_i);
    if (omode2_i == pzt_pkg::PZT_OM_TR_S ||
        omode2_i == pzt_pkg::PZT_OM_TR_D)
      thr2 = 34'(pre1_i) - 34'(pre2_i);
    le2  = (omode2_i == pzt_pkg::PZT_OM_LE_S) ||
           (omode2_i == pzt_pkg::PZT_OM_LE_D);
    dyn2 = (omode2_i == pzt_pkg::PZT_OM_GE_D) ||
           (omode2_i == pzt_pkg::PZT_OM_LE_D) ||
           (omode2_i == pzt_pkg::PZT_OM_TR_D);
  end

  // Hysteretic compare: on at threshold, off past deadband
  function automatic logic hcmp(input logic signed [33:0] v,
                                input logic signed [33:0] t,
                                input logic signed [33:0] h,
                                input logic le, input logic st);
    if (!le) hcmp = st ? (v >= t - h) : (v >= t);   // GE releases below
    else     hcmp = st ? (v <= t + h) : (v <= t);   // LE releases above
  endfunction

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      st1_q <= 1'b0;
      st2_q <= 1'b0;
    end else if (ce_i) begin
      st1_q <= hcmp(34'(disp_q), thr1, 34'(output_one_deadband_i),
                    le1, st1_q);
      st2_q <= hcmp(34'(disp_q), thr2, 34'(output_two_deadband_i),
                    le2, st2_q);
    end
  end

  // Pulse timers for dynamic mode
  logic [31:0] p1_q, p2_q;                          // Remaining cycles
  logic        s1d_q, s2d_q;                        // Previous states
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      p1_q  <= 32'h0000_0000;
      p2_q  <= 32'h0000_0000;
      s1d_q <= 1'b0;
      s2d_q <= 1'b0;
    end else if (ce_i) begin
      s1d_q <= st1_q;
      s2d_q <= st2_q;
      if (st1_q && !s1d_q) p1_q <= 32'(PULSE_CYC);
      else if (p1_q != 32'h0000_0000) p1_q <= p1_q - 32'h0000_0001;
      if (st2_q && !s2d_q) p2_q <= 32'(PULSE_CYC);
      else if (p2_q != 32'h0000_0000) p2_q <= p2_q - 32'h0000_0001;
    end
  end
  assign out1_o = dyn1 ? (p1_q != 32'h0000_0000) : st1_q;
  assign out2_o = dyn2 ? (p2_q != 32'h0000_0000) : st2_q;

  // Output state readback
  logic [31:0] sh_q;                                // Show timer
  logic [1:0]  code_q;                              // Latched code
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      sh_q   <= 32'h0000_0000;
      code_q <= pzt_pkg::PZT_ST_NONE;
    end else if (ce_i) begin
      if (enter_tap_i) sh_q <= 32'(STATUS_CYC);
      else if (sh_q != 32'h0000_0000) sh_q <= sh_q - 32'h0000_0001;
      unique case ({out1_o, out2_o})
        2'b00: code_q <= pzt_pkg::PZT_ST_NONE;
        2'b11: code_q <= pzt_pkg::PZT_ST_BOTH;
        2'b10: code_q <= pzt_pkg::PZT_ST_ONE;
        2'b01: code_q <= pzt_pkg::PZT_ST_TWO;
      endcase
    end
  end
  assign stat_show_o = sh_q != 32'h0000_0000;
  assign stat_code_o = code_q;

  // Checks
  zero_cap_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    ce_i && !boot_q && zero_cmd |=> zero_q == $past(pos_q))
    else $error("datum not captured");
  src_off_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    zero_capture_source_i == 2'b00 |-> !zero_cmd)
    else $error("disabled source accepted");
  nv_store_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    ce_i && !boot_q && (zero_cmd || zero_wr_i) |=> zero_nv_wr_o)
    else $error("datum not stored");
  pt_gate_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    ce_i && pt_wr_i && !lin_en_i && !pt_sel_y_i
    |=> px_q[$past(pt_idx_i)] == $past(px_q[pt_idx_i]))
    else $error("point written while disabled");
  aneg_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    aout_neg_o |-> amode_i == 2'b00 || $changed(amode_i))
    else $error("sign outside bipolar mode");
  ge_cmp_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    ce_i && !le1 && output_one_deadband_i == 32'sh0000_0000
    |=> st1_q == ($past(disp_q) >= $past(pre1_i)))
    else $error("threshold compare wrong");
  pulse_len_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    ce_i && st1_q && !s1d_q |=> p1_q == 32'(PULSE_CYC))
    else $error("pulse length wrong");
  stat_tap_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    ce_i && enter_tap_i |=> stat_show_o)
    else $error("status not shown");
  stat_code_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    ce_i |=> stat_code_o == {$past(out1_o) ^ $past(out2_o), $past(out2_o)})
    else $error("status code wrong");
  disp_zero_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    ce_i && pos_q == zero_q |=> disp_q == $past(add_fac_i))
    else $error("display not zero at datum");

endmodule
`default_nettype wire

// [tb/pzt_enc_model.sv]
// Position source and switching loads that time the output pulses
`timescale 1ns/1ps
`default_nettype none
module pzt_enc_model (
  input  wire logic          clk_i,     // System clock
  input  wire logic          out1_i,    // Switching output 1
  input  wire logic          out2_i,    // Switching output 2
  output logic signed [31:0] pos_o,     // Position word
  output logic               pos_vld_o, // Word strobe
  output var int             len1_o,    // Last on span, output 1
  output var int             len2_o,    // Last on span, output 2
  output var int             cnt1_o,    // On spans seen, output 1
  output var int             cnt2_o     // On spans seen, output 2
);
  int run1; // Cycles on so far, output 1
  int run2; // Cycles on so far, output 2
  // Idle source, no spans seen yet
  initial begin
    pos_o = 32'sh0000_0000;
    pos_vld_o = 1'b0;
    {run1, run2, len1_o, len2_o, cnt1_o, cnt2_o} = '0;
  end
  // One word for one cycle, changed just after a falling edge
  task automatic send(input logic signed [31:0] v);
    @(negedge clk_i);
    pos_o <= v;
    pos_vld_o <= 1'b1;
    @(negedge clk_i);
    pos_vld_o <= 1'b0;
    pos_o <= ~v; // Word no longer valid, so show a changed one
  endtask
  // Loads measure each on span as the outputs drop
  always @(posedge clk_i) begin
    if (out1_i) run1 <= run1 + 1;
    else if (run1 != 0) begin
      len1_o <= run1;
      cnt1_o <= cnt1_o + 1;
      run1 <= 0;
    end
    if (out2_i) run2 <= run2 + 1;
    else if (run2 != 0) begin
      len2_o <= run2;
      cnt2_o <= cnt2_o + 1;
      run2 <= 0;
    end
  end
endmodule
`default_nettype wire

// [tb/pzt_core_bench.sv]
// Self-checking bench for the zero, window and preset block
`timescale 1ns/1ps
`default_nettype none
module pzt_core_bench;
  localparam int PCYC = 20;                 // Short pulse length
  localparam int SCYC = 40;                 // Short status time
  logic sys_clk = 1'b0;                     // Bench clock
  logic rst_b, ce, key, rem, zwr, lin, ptwr, ptsy, tap; // Bit inputs
  logic pvld, znvwr, ptok, aneg, o1, o2, show; // Bit outputs
  logic [1:0] src, amode, code;             // Selectors, status
  logic [2:0] om1, om2;                     // Output modes
  logic [3:0] ptidx;                        // Point index
  logic [15:0] dvf;                         // Divide factor
  logic signed [15:0] mul;                  // Multiply factor
  logic [31:0] aswing, rnd;                 // Gain, random state
  logic signed [31:0] add, zwd, znv, ptwd, azl, abeg, aend, pre1, pre2;
  logic signed [31:0] h1, h2, pos, zpos, ptx, pty, aout, disp, p, q;
  int len1, len2, cnt1, cnt2, err_count, cmp_count; // Loads, tallies
  always #2.5 sys_clk = ~sys_clk;           // 200 MHz
  pzt_enc_model i_pzt_enc_model (.clk_i(sys_clk), .out1_i(o1),
    .out2_i(o2), .pos_o(pos), .pos_vld_o(pvld), .len1_o(len1),
    .len2_o(len2), .cnt1_o(cnt1), .cnt2_o(cnt2));
  pzt_core #(.PULSE_CYC(PCYC), .STATUS_CYC(SCYC)) i_pzt_core (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b), .ce_i(ce), .pos_i(pos),
    .pos_vld_i(pvld), .mul_fac_i(mul), .div_fac_i(dvf), .add_fac_i(add),
    .zero_capture_source_i(src), .key_set_i(key),
    .remote_input_source_i(rem), .zero_wr_i(zwr), .zero_wdata_i(zwd),
    .zero_nv_i(znv), .zero_position_value_o(zpos), .zero_nv_wr_o(znvwr),
    .lin_en_i(lin), .pt_wr_i(ptwr), .pt_idx_i(ptidx), .pt_sel_y_i(ptsy),
    .pt_wdata_i(ptwd), .pt_x_o(ptx), .pt_y_o(pty), .pt_wr_ok_o(ptok),
    .amode_i(amode), .analog_zero_level_i(azl), .analog_swing_i(aswing),
    .analog_window_begin_i(abeg), .analog_window_end_i(aend),
    .aout_o(aout), .aout_neg_o(aneg), .omode1_i(om1), .omode2_i(om2),
    .pre1_i(pre1), .pre2_i(pre2), .output_one_deadband_i(h1),
    .output_two_deadband_i(h2), .out1_o(o1), .out2_o(o2),
    .enter_tap_i(tap), .stat_show_o(show), .stat_code_o(code),
    .disp_o(disp));
  // Compare and tally
  task automatic chk(input string nm, input logic signed [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %0d seen %0d", nm, e, s);
    end
  endtask
  // Wait whole cycles, ending on a falling edge
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // New position, then let the display and outputs settle
  task automatic put(input logic signed [31:0] v);
    i_pzt_enc_model.send(v);
    step(4);
  endtask
  // Direct datum write
  task automatic zset(input logic signed [31:0] v);
    zwd = v;
    zwr = 1'b1;
    step(1);
    zwr = 1'b0;
    chk("nv_store", 32'(znvwr), 32'sh0000_0001);
    step(2);
  endtask
  // Xorshift draw inside the accepted value range
  function automatic logic signed [31:0] rval();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return pzt_pkg::VAL_MIN + 32'(rnd % 32'h0012_4F7F);
  endfunction
  // Expected analogue level for a display value
  function automatic logic signed [31:0] ana(input logic signed [31:0] d);
    longint x;
    x = (amode == 2'h0 && d < 0) ? -d : d;
    x = (x < abeg) ? abeg : (x > aend) ? aend : x;
    x = (x - abeg) * aswing * (amode == 2'h2 ? 16 : amode[1] ? 20 : 10)
      / (aend - abeg);
    if (amode == 2'h2) x = x + pzt_pkg::I4_BASE;
    return 32'(x + azl);
  endfunction
  // Expected status code from the two output states
  function automatic logic [1:0] scode(input logic a, b);
    return (a && b) ? 2'h1 : a ? 2'h2 : b ? 2'h3 : 2'h0;
  endfunction
  // Verdict
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog far beyond the expected run
  initial begin
    #100_000;
    err_count++;
    tally_and_finish();
  end
  // Test sequence
  initial begin
    {err_count, cmp_count} = '0;
    {rst_b, key, rem, zwr, lin, ptwr, ptsy, tap, ptidx} = '0;
    ce = 1'b1;
    rnd = 32'h0001_0ED8;
    mul = pzt_pkg::UNITY;
    dvf = pzt_pkg::UNITY;
    {add, zwd, ptwd, azl, abeg, h1, h2} = '0;
    znv = 32'sh0000_0309;
    src = 2'h0;
    amode = 2'h1;
    aswing = pzt_pkg::AGAIN_DEF;
    aend = pzt_pkg::WEND_DEF;
    om1 = pzt_pkg::PZT_OM_GE_S;
    om2 = pzt_pkg::PZT_OM_LE_S;
    pre1 = pzt_pkg::PRE1_DEF;
    pre2 = pzt_pkg::PRE2_DEF;
    step(2);
    rst_b = 1'b1;
    step(2);
    chk("datum_boot", zpos, znv);
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      src = 2'(s);
      p = rval();
      put(p);
      zset(32'sh0000_0111);
      key = 1'b1;
      step(1);
      key = 1'b0;
      step(2);
      chk("datum_key", zpos, s[0] ? p : 32'sh0000_0111);
      zset(32'sh0000_0111);
      rem = 1'b1;
      step(5);
      rem = 1'b0;
      step(2);
      chk("datum_rem", zpos, s[1] ? p : 32'sh0000_0111);
    end
    put(p);
    chk("disp_at_datum", disp, 32'sh0000_0000);
    add = 32'sh0000_007B;
    put(p);
    chk("disp_offset", disp, 32'sh0000_007B);
    q = rval();
    put(q);
    zwd = 32'sh0000_0222;
    zwr = 1'b1;
    key = 1'b1;
    step(1);
    {zwr, key} = '0;
    step(2);
    chk("datum_cmd_wins", zpos, q);
    zset(32'sh0000_0222);
    chk("datum_last", zpos, 32'sh0000_0222);
    zset(32'sh0000_0000);
    add = '0;
    $display("test zero done");
    ptidx = 4'h3;
    ptwd = 32'sh0000_002A;
    ptwr = 1'b1;
    #1 chk("pt_ok_off", 32'(ptok), 32'sh0000_0000);
    step(1);
    lin = 1'b1;
    #1 chk("pt_x_kept", ptx, pzt_pkg::IPT_DEF);
    chk("pt_ok_on", 32'(ptok), 32'sh0000_0001);
    step(1);
    {ptsy, ptidx} = 5'h1F;
    ptwd = -32'sh0000_0007;
    step(1);
    ptwr = 1'b0;
    #1 chk("pt_y_last", pty, -32'sh0000_0007);
    {ptsy, ptidx} = 5'h03;
    #1 chk("pt_x_wr", ptx, 32'sh0000_002A);
    $display("test points done");
    for (int m = 0; m < 4; m++) begin
      amode = 2'(m);
      for (int j = 0; j < 3; j++) begin
        p = (j == 0) ? -32'sh0000_C350 : (j == 1) ? 32'sh0000_C350
          : 32'sh0002_49F0;
        put(p);
        chk("aout", aout, ana(p));
        chk("aout_neg", 32'(aneg), 32'(m == 0 && j == 0));
      end
    end
    amode = 2'h1;
    azl = 32'sh0000_01F4;
    abeg = 32'sh0000_2710;
    add = 32'sh0000_1388;
    put(32'sh0000_C350);
    chk("aout_ofs", aout, ana(32'sh0000_D6D8));
    add = '0;
    $display("test analogue done");
    for (int i = 0; i < 24; i++) begin
      p = (i == 0) ? pre1 : (i == 1) ? pre2 : rval();
      put(p);
      chk("out1_ge", 32'(o1), 32'(p >= pre1));
      chk("out2_le", 32'(o2), 32'(p <= pre2));
      if (i == 1) pre2 = rval();
    end
    pre2 = pzt_pkg::PRE2_DEF;
    for (int k = 0; k < 4; k++) begin
      om2 = k[1] ? pzt_pkg::PZT_OM_GE_S : pzt_pkg::PZT_OM_LE_S;
      p = k[0] ? 32'sh0000_0000 : 32'sh0000_4E20;
      put(p);
      tap = 1'b1;
      step(1);
      tap = 1'b0;
      #1 chk("stat_show", 32'(show), 32'sh0000_0001);
      chk("stat_code", 32'(code), 32'(scode(p >= pre1,
        k[1] ? p >= pre2 : p <= pre2)));
    end
    step(SCYC + 2);
    chk("stat_gone", 32'(show), 32'sh0000_0000);
    $display("test static done");
    om2 = pzt_pkg::PZT_OM_LE_S;
    pre2 = pre1;
    h1 = 32'sh0000_0064;
    h2 = 32'sh0000_0064;
    put(32'sh0000_0000);
    for (int i = 0; i < 8; i++) begin
      p = (i == 0 || i == 4) ? 32'sh0000_2710 : (i == 1 || i == 3)
        ? 32'sh0000_26DE : (i == 2) ? 32'sh0000_26AB : (i == 6)
        ? 32'sh0000_2775 : 32'sh0000_2742;
      put(p);
      chk("hys_ge", 32'(o1), 32'(8'b1111_0011 >> i) & 1);
      chk("hys_le", 32'(o2), 32'(8'b0011_1111 >> i) & 1);
    end
    {h1, h2} = '0;
    pre2 = pzt_pkg::PRE2_DEF;
    om2 = pzt_pkg::PZT_OM_TR_S;
    put(32'sh0000_1387);
    chk("trail_off", 32'(o2), 32'sh0000_0000);
    put(32'sh0000_1388);
    chk("trail_on", 32'(o2), 32'sh0000_0001);
    ce = 1'b0;
    put(32'sh0000_0777);
    chk("ce_freeze", disp, 32'sh0000_1388);
    ce = 1'b1;
    step(PCYC);
    om1 = pzt_pkg::PZT_OM_GE_D;
    om2 = pzt_pkg::PZT_OM_TR_D;
    put(32'sh0000_0000);
    put(32'sh0000_2EE0);
    step(PCYC + 4);
    chk("pulse_ge", 32'(len1), 32'(PCYC));
    chk("pulse_tr", 32'(len2), 32'(PCYC));
    chk("held_off", 32'(o1), 32'sh0000_0000);
    om1 = pzt_pkg::PZT_OM_LE_D;
    q = 32'(cnt1);
    put(32'sh0000_0000);
    step(PCYC + 4);
    chk("pulse_le", 32'(cnt1), q + 1);
    $display("test pulse done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
